// file: src/ubd_baud_gen.sv
// fractional baud generator: tick at sixteen times the bit rate
`include "ubd_regs.svh"
module ubd_baud_gen
	import ubd_pkg::*;
(
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	ubd_baud_if.gen   bif
);
	logic [15:0] cnt_q;
	logic [6:0]  frac_acc_q;
	logic [6:0]  frac_sum;
	logic [15:0] whole_eff;
	logic        wrap;

	// zero integer divisor means divide by one
	assign whole_eff = (bif.divisor_whole == `UBD_DIVISOR_WHOLE_RST) ? 16'h0001 : bif.divisor_whole;
	assign frac_sum  = {1'b0, frac_acc_q[5:0]} + {1'b0, bif.divisor_fraction};
	// period is whole + fraction/64: one extra clock each fraction carry
	// one bit wider so the largest divisor plus a carry does not wrap to zero
	assign wrap      = ({1'b0, cnt_q} + 17'h00001) >= ({1'b0, whole_eff} + {16'h0000, frac_sum[6]});

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q      <= 16'h0000;
			frac_acc_q <= 7'h00;
			bif.tick   <= 1'b0;
		end else if (ce) begin
			bif.tick <= wrap;
			if (wrap) begin
				cnt_q      <= 16'h0000;
				frac_acc_q <= {1'b0, frac_sum[5:0]};
			end else begin
				cnt_q <= cnt_q + 16'h0001;
			end
		end
	end

	a_zero_div_tick : assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && bif.divisor_whole == 16'h0000 && bif.divisor_fraction == 6'h00) ##1 ce |-> bif.tick)
		else $error("zero divisor does not tick every clock");
endmodule

// file: src/ubd_baud_if.sv
// carries the latched divisor and the sampling tick between modules
interface ubd_baud_if;
	logic [15:0] divisor_whole;
	logic [5:0]  divisor_fraction;
	logic        tick;
	modport gen (input divisor_whole, input divisor_fraction, output tick);
	modport use_side (output divisor_whole, output divisor_fraction, input tick);
endinterface

// file: src/ubd_pkg.sv
// shared types for the serial port flag and baud divisor block
package ubd_pkg;
	typedef enum logic [1:0] {UBD_TX_IDLE, UBD_TX_START, UBD_TX_DATA, UBD_TX_STOP} ubd_tx_state_t;
	typedef enum logic [1:0] {UBD_RX_IDLE, UBD_RX_START, UBD_RX_DATA, UBD_RX_STOP} ubd_rx_state_t;
endpackage

// file: src/ubd_regs.svh
// register map, field positions, reset values and timing constants
`ifndef UBD_REGS_SVH
`define UBD_REGS_SVH
`define UBD_OFF_DATA      12'h000
`define UBD_OFF_FLAGS     12'h018
`define UBD_OFF_DIVISOR_WHOLE    12'h024
`define UBD_OFF_DIVISOR_FRACTION   12'h028
`define UBD_OFF_FRAME     12'h02c
`define UBD_OFF_IRQ_STAT  12'h040
`define UBD_OFF_IRQ_MASK  12'h044
`define UBD_FLG_TXE       7
`define UBD_FLG_RXF       6
`define UBD_FLG_TXF       5
`define UBD_FLG_RXE       4
`define UBD_FLG_BUSY      3
`define UBD_FRM_QEN       4
`define UBD_FRM_W         8
`define UBD_DIVISOR_WHOLE_W      16
`define UBD_DIVISOR_FRACTION_W     6
`define UBD_DIVISOR_WHOLE_RST    16'h0000
`define UBD_DIVISOR_FRACTION_RST   6'h00
`define UBD_FRAME_RST     8'h00
`define UBD_QDEPTH        16
`define UBD_QPTR_W        4
`define UBD_QCNT_W        5
`define UBD_OVS_LAST      4'hf
`define UBD_OVS_MID       4'h7
`define UBD_DATA_BITS     4'h8
`define UBD_IRQ_W         3
`define UBD_IRQ_TXDONE    0
`define UBD_IRQ_RXGOT     1
`define UBD_IRQ_RXOVR     2
`define UBD_RESP_OKAY     2'b00
`define UBD_RESP_SLVERR   2'b10
`endif

// file: src/ubd_top.sv
// serial port with flag register, baud divisors and axi4-lite registers
//
// Implementation choice: the AXI4-Lite slave port.
`include "ubd_regs.svh"
module ubd_top
	import ubd_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic        port_enable,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        rx_line,
	output logic             tx_line,
	output logic             irq
);
	// ------------------------------------------------------------
	// register storage
	// ------------------------------------------------------------
	logic [15:0]            div_int_q;
	logic [5:0]             div_frac_q;
	logic [`UBD_FRM_W-1:0]  frame_q;
	logic [15:0]            act_int_q;
	logic [5:0]             act_frac_q;
	logic [15:0]            pend_int_q;
	logic [5:0]             pend_frac_q;
	logic                   pend_q;
	logic [`UBD_IRQ_W-1:0]  irq_stat_q;
	logic [`UBD_IRQ_W-1:0]  irq_mask_q;

	ubd_baud_if bif ();
	assign bif.divisor_whole    = act_int_q;
	assign bif.divisor_fraction = act_frac_q;

	ubd_baud_gen u_baud (
		.aclk    (aclk),
		.aresetn (aresetn),
		.ce      (ce),
		.bif     (bif)
	);

	// ------------------------------------------------------------
	// axi4-lite write path
	// ------------------------------------------------------------
	logic        aw_have_q;
	logic        w_have_q;
	logic [11:0] aw_addr_q;
	logic [31:0] w_data_q;
	logic [3:0]  w_strb_q;
	wire         wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
	wire         wr_data  = wr_fire && (aw_addr_q == `UBD_OFF_DATA);
	wire         wr_int   = wr_fire && (aw_addr_q == `UBD_OFF_DIVISOR_WHOLE);
	wire         wr_frac  = wr_fire && (aw_addr_q == `UBD_OFF_DIVISOR_FRACTION);
	wire         wr_frame = wr_fire && (aw_addr_q == `UBD_OFF_FRAME);
	wire         wr_mask  = wr_fire && (aw_addr_q == `UBD_OFF_IRQ_MASK);
	wire         wr_map   = wr_data || wr_int || wr_frac || wr_frame || wr_mask;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_q     <= 1'b0;
			w_have_q      <= 1'b0;
			aw_addr_q     <= 12'h000;
			w_data_q      <= 32'h0000_0000;
			w_strb_q      <= 4'h0;
			s_axi_awready <= 1'b1;
			s_axi_wready  <= 1'b1;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `UBD_RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_q     <= 1'b1;
				aw_addr_q     <= {s_axi_awaddr[11:2], 2'b00};
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_q     <= 1'b1;
				w_data_q     <= s_axi_wdata;
				w_strb_q     <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (wr_fire) begin
				aw_have_q    <= 1'b0;
				w_have_q     <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= wr_map ? `UBD_RESP_OKAY : `UBD_RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready  <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// divisor and frame registers, latching on frame write
	// ------------------------------------------------------------
	logic tx_active;
	logic rx_active;
	wire  char_idle = !tx_active && !rx_active;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			div_int_q   <= `UBD_DIVISOR_WHOLE_RST;
			div_frac_q  <= `UBD_DIVISOR_FRACTION_RST;
			frame_q     <= `UBD_FRAME_RST;
			act_int_q   <= `UBD_DIVISOR_WHOLE_RST;
			act_frac_q  <= `UBD_DIVISOR_FRACTION_RST;
			pend_int_q  <= `UBD_DIVISOR_WHOLE_RST;
			pend_frac_q <= `UBD_DIVISOR_FRACTION_RST;
			pend_q      <= 1'b0;
			irq_mask_q  <= {`UBD_IRQ_W{1'b0}};
		end else if (ce) begin
			// only the low bytes are stored; reserved bits drop writes
			if (wr_int && w_strb_q[0]) div_int_q[7:0]  <= w_data_q[7:0];
			if (wr_int && w_strb_q[1]) div_int_q[15:8] <= w_data_q[15:8];
			if (wr_frac && w_strb_q[0]) div_frac_q <= w_data_q[`UBD_DIVISOR_FRACTION_W-1:0];
			if (wr_frame && w_strb_q[0]) frame_q <= w_data_q[`UBD_FRM_W-1:0];
			if (wr_mask && w_strb_q[0]) irq_mask_q <= w_data_q[`UBD_IRQ_W-1:0];
			if (wr_frame) begin
				// divisor strobe is the frame control write
				pend_int_q  <= div_int_q;
				pend_frac_q <= div_frac_q;
				pend_q      <= 1'b1;
			end else if (pend_q && char_idle) begin
				// hold off until no character is on the line
				act_int_q  <= pend_int_q;
				act_frac_q <= pend_frac_q;
				pend_q     <= 1'b0;
			end
		end
	end

	a_div_waits_char : assert property (@(posedge aclk) disable iff (!aresetn)
		(tx_active && !$stable(act_int_q)) |-> $past(char_idle))
		else $error("divisor changed during a character");
	a_div_needs_frame : assert property (@(posedge aclk) disable iff (!aresetn)
		!$stable(pend_int_q) |-> $past(wr_frame && ce))
		else $error("divisor taken without frame write");

	// ------------------------------------------------------------
	// transmit queue and shifter
	// ------------------------------------------------------------
	wire                  queue_enable = frame_q[`UBD_FRM_QEN];
	logic [7:0]           txq_mem [`UBD_QDEPTH];
	logic [`UBD_QPTR_W-1:0] txq_rd_q;
	logic [`UBD_QPTR_W-1:0] txq_wr_q;
	logic [`UBD_QCNT_W-1:0] txq_cnt_q;
	wire  [`UBD_QCNT_W-1:0] q_cap = queue_enable ? `UBD_QCNT_W'(`UBD_QDEPTH) : `UBD_QCNT_W'(1);
	wire                  tx_queue_empty = (txq_cnt_q == '0);
	wire                  tx_queue_full  = (txq_cnt_q >= q_cap);
	ubd_tx_state_t        tx_st_q;
	logic [3:0]           tx_ovs_q;
	logic [3:0]           tx_bit_q;
	logic [7:0]           tx_sh_q;
	wire                  tx_push = wr_data && w_strb_q[0] && !tx_queue_full;
	wire                  tx_pop  = (tx_st_q == UBD_TX_IDLE) && !tx_queue_empty && port_enable;
	wire                  bit_end_tx = bif.tick && (tx_ovs_q == `UBD_OVS_LAST);
	wire                  tx_done = (tx_st_q == UBD_TX_STOP) && bit_end_tx;
	assign tx_active = (tx_st_q != UBD_TX_IDLE);

	always_ff @(posedge aclk) begin
		if (ce && tx_push) txq_mem[txq_wr_q] <= w_data_q[7:0];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			txq_rd_q  <= '0;
			txq_wr_q  <= '0;
			txq_cnt_q <= '0;
			tx_st_q   <= UBD_TX_IDLE;
			tx_ovs_q  <= 4'h0;
			tx_bit_q  <= 4'h0;
			tx_sh_q   <= 8'h00;
			tx_line   <= 1'b1;
		end else if (ce) begin
			if (tx_push) txq_wr_q <= txq_wr_q + 1'b1;
			if (tx_pop) txq_rd_q <= txq_rd_q + 1'b1;
			txq_cnt_q <= txq_cnt_q + `UBD_QCNT_W'(tx_push) - `UBD_QCNT_W'(tx_pop);
			if (bif.tick) tx_ovs_q <= tx_ovs_q + 4'h1;
			case (tx_st_q)
				UBD_TX_IDLE: begin
					tx_line  <= 1'b1;
					tx_ovs_q <= 4'h0;
					if (tx_pop) begin
						tx_sh_q <= txq_mem[txq_rd_q];
						tx_st_q <= UBD_TX_START;
						tx_line <= 1'b0;
					end
				end
				UBD_TX_START: begin
					if (bit_end_tx) begin
						tx_line  <= tx_sh_q[0];
						tx_bit_q <= 4'h1;
						tx_st_q  <= UBD_TX_DATA;
					end
				end
				UBD_TX_DATA: begin
					if (bit_end_tx) begin
						if (tx_bit_q == `UBD_DATA_BITS) begin
							tx_line <= 1'b1;
							tx_st_q <= UBD_TX_STOP;
						end else begin
							tx_line  <= tx_sh_q[tx_bit_q[2:0]];
							tx_bit_q <= tx_bit_q + 4'h1;
						end
					end
				end
				UBD_TX_STOP: begin
					// busy holds through the whole stop bit
					if (bit_end_tx) tx_st_q <= UBD_TX_IDLE;
				end
				default: tx_st_q <= UBD_TX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// receiver with queue
	// ------------------------------------------------------------
	logic [7:0]             rxq_mem [`UBD_QDEPTH];
	logic [`UBD_QPTR_W-1:0] rxq_rd_q;
	logic [`UBD_QPTR_W-1:0] rxq_wr_q;
	logic [`UBD_QCNT_W-1:0] rxq_cnt_q;
	wire                    rx_queue_empty = (rxq_cnt_q == '0);
	wire                    rx_queue_full  = (rxq_cnt_q >= q_cap);
	ubd_rx_state_t          rx_st_q;
	logic [3:0]             rx_ovs_q;
	logic [3:0]             rx_bit_q;
	logic [7:0]             rx_sh_q;
	logic                   rd_data;
	wire                    rx_mid = bif.tick && (rx_ovs_q == `UBD_OVS_MID);
	wire                    rx_got = (rx_st_q == UBD_RX_STOP) && rx_mid && rx_line;
	wire                    rx_push = rx_got && !rx_queue_full;
	wire                    rx_pop  = rd_data && !rx_queue_empty;
	assign rx_active = (rx_st_q != UBD_RX_IDLE);

	always_ff @(posedge aclk) begin
		if (ce && rx_push) rxq_mem[rxq_wr_q] <= rx_sh_q;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rxq_rd_q  <= '0;
			rxq_wr_q  <= '0;
			rxq_cnt_q <= '0;
			rx_st_q   <= UBD_RX_IDLE;
			rx_ovs_q  <= 4'h0;
			rx_bit_q  <= 4'h0;
			rx_sh_q   <= 8'h00;
		end else if (ce) begin
			if (rx_push) rxq_wr_q <= rxq_wr_q + 1'b1;
			if (rx_pop) rxq_rd_q <= rxq_rd_q + 1'b1;
			rxq_cnt_q <= rxq_cnt_q + `UBD_QCNT_W'(rx_push) - `UBD_QCNT_W'(rx_pop);
			if (bif.tick) rx_ovs_q <= rx_ovs_q + 4'h1;
			case (rx_st_q)
				UBD_RX_IDLE: begin
					rx_ovs_q <= 4'h0;
					if (!rx_line && port_enable) rx_st_q <= UBD_RX_START;
				end
				UBD_RX_START: begin
					if (rx_mid) begin
						rx_st_q  <= rx_line ? UBD_RX_IDLE : UBD_RX_DATA;
						rx_bit_q <= 4'h0;
					end
				end
				UBD_RX_DATA: begin
					if (rx_mid) begin
						rx_sh_q  <= {rx_line, rx_sh_q[7:1]};
						rx_bit_q <= rx_bit_q + 4'h1;
						if (rx_bit_q == `UBD_DATA_BITS - 4'h1) rx_st_q <= UBD_RX_STOP;
					end
				end
				UBD_RX_STOP: begin
					if (rx_mid) rx_st_q <= UBD_RX_IDLE;
				end
				default: rx_st_q <= UBD_RX_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------
	// flags, interrupts and read path
	// ------------------------------------------------------------
	// busy covers queued bytes too, whether or not the port is enabled
	wire       busy = tx_active || !tx_queue_empty;
	wire [7:0] flags = {tx_queue_empty, rx_queue_full, tx_queue_full, rx_queue_empty, busy, 3'b000};
	wire [`UBD_IRQ_W-1:0] irq_ev = {rx_got && rx_queue_full, rx_push, tx_done};
	logic [11:0] ar_addr;
	logic        rd_fire;
	logic        rd_stat;
	logic [31:0] rd_word;
	logic        rd_map;
	assign ar_addr = {s_axi_araddr[11:2], 2'b00};
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign rd_data = rd_fire && (ar_addr == `UBD_OFF_DATA);
	assign rd_stat = rd_fire && (ar_addr == `UBD_OFF_IRQ_STAT);
	assign rd_map  = (ar_addr == `UBD_OFF_DATA) || (ar_addr == `UBD_OFF_FLAGS) ||
		(ar_addr == `UBD_OFF_DIVISOR_WHOLE) || (ar_addr == `UBD_OFF_DIVISOR_FRACTION) || (ar_addr == `UBD_OFF_FRAME) ||
		(ar_addr == `UBD_OFF_IRQ_STAT) || (ar_addr == `UBD_OFF_IRQ_MASK);
	// reserved bits read zero
	assign rd_word =
		(ar_addr == `UBD_OFF_DATA)     ? {24'h000000, rx_queue_empty ? 8'h00 : rxq_mem[rxq_rd_q]} :
		(ar_addr == `UBD_OFF_FLAGS)    ? {24'h000000, flags} :
		(ar_addr == `UBD_OFF_DIVISOR_WHOLE)   ? {16'h0000, div_int_q} :
		(ar_addr == `UBD_OFF_DIVISOR_FRACTION)  ? {26'h0000000, div_frac_q} :
		(ar_addr == `UBD_OFF_FRAME)    ? {24'h000000, frame_q} :
		(ar_addr == `UBD_OFF_IRQ_STAT) ? {29'h00000000, irq_stat_q} :
		(ar_addr == `UBD_OFF_IRQ_MASK) ? {29'h00000000, irq_mask_q} : 32'h0000_0000;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `UBD_RESP_OKAY;
			irq_stat_q    <= {`UBD_IRQ_W{1'b0}};
			irq           <= 1'b0;
		end else if (ce) begin
			if (rd_fire) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= rd_map ? `UBD_RESP_OKAY : `UBD_RESP_SLVERR;
			end
			if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid  <= 1'b0;
				s_axi_arready <= 1'b1;
			end
			// new events win over the clear-on-read
			irq_stat_q <= (rd_stat ? {`UBD_IRQ_W{1'b0}} : irq_stat_q) | irq_ev;
			irq        <= |(((rd_stat ? {`UBD_IRQ_W{1'b0}} : irq_stat_q) | irq_ev) & irq_mask_q);
		end
	end

	a_busy_on_queue : assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && tx_push) |=> flags[`UBD_FLG_BUSY])
		else $error("busy low after a byte was queued");
	a_busy_through_stop : assert property (@(posedge aclk) disable iff (!aresetn)
		$fell(flags[`UBD_FLG_BUSY]) |-> $past(tx_done))
		else $error("busy dropped before stop bit ended");
	a_flag_empty_full : assert property (@(posedge aclk) disable iff (!aresetn)
		!(flags[`UBD_FLG_TXE] && flags[`UBD_FLG_TXF]) && !(flags[`UBD_FLG_RXE] && flags[`UBD_FLG_RXF]))
		else $error("empty and full flags both set");
	a_char_mode_full : assert property (@(posedge aclk) disable iff (!aresetn)
		(!queue_enable && txq_cnt_q == 5'h01) |-> flags[`UBD_FLG_TXF])
		else $error("holding register full not flagged");
	a_reset_flags : assert property (@(posedge aclk)
		$rose(aresetn) |-> (flags == 8'h90))
		else $error("flags wrong after reset");
	a_rx_empty_flag : assert property (@(posedge aclk) disable iff (!aresetn)
		(ce && rx_push) |=> !flags[`UBD_FLG_RXE])
		else $error("rx empty flag stuck after receive");
endmodule

// file: verification/uart_flags_and_baud_divisor_bench.sv
// self-checking bench for the serial port flag and divisor block
`include "ubd_regs.svh"
module uart_flags_and_baud_divisor_bench;
	timeunit 1ns;
	timeprecision 1ps;

	logic        aclk, aresetn, pe, awvalid, wvalid, arvalid;
	logic        awready, wready, bvalid, arready, rvalid, rx_line, tx_line, irq;
	logic [31:0] awaddr, wdata, araddr, rdata, d, v;
	logic [1:0]  bresp, rresp, rr;
	logic [7:0]  b;
	logic [7:0]  exp_q[$];
	int          fails, checked, cyc, n, t0;
	int          wt[4] = '{2, 0, 1, 3};
	int          ft[4] = '{0, 0, 32, 16};

	ubd_top uut (
		.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .port_enable(pe),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(1'b1),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1),
		.rx_line(rx_line), .tx_line(tx_line), .irq(irq)
	);

	ubd_far_end far (.aclk(aclk), .tx_line(tx_line), .rx_line(rx_line));

	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end

	always @(posedge aclk) cyc <= cyc + 1;

	// ------------------------------
	// expectations
	// ------------------------------
	function automatic logic [31:0] fl(input logic te, rf, tf, re, bz);
		return {24'h0, te, rf, tf, re, bz, 3'h0};
	endfunction

	// clocks per bit: sixteen ticks, tick of whole plus fraction over 64
	function automatic int bclk(input int wi, input int fr);
		return 16 * (wi == 0 ? 1 : wi) + fr / 4;
	endfunction

	// ------------------------------
	// bus and compare tasks
	// ------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		checked++;
		if (g !== e) begin
			fails++;
			$display("BAD t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] x);
		awaddr <= {20'h0, a};
		wdata <= x;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready === 1'b1) awvalid <= 1'b0;
			if (wready === 1'b1) wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		rr = bresp;
	endtask

	task automatic rd(input logic [11:0] a, output logic [31:0] x);
		araddr <= {20'h0, a};
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready === 1'b1) arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		x = rdata;
		rr = rresp;
	endtask

	task automatic rchk(input logic [11:0] a, input logic [31:0] m, input logic [31:0] e);
		rd(a, d);
		chk(d & m, e);
	endtask

	task automatic put(input logic [7:0] x);
		exp_q.push_back(x);
		wr(`UBD_OFF_DATA, {24'h0, x});
	endtask

	// waits for the far end to hold every expected byte, then compares
	task automatic rx_cmp;
		int k;
		k = 0;
		while (far.got_q.size() < exp_q.size() && k < 20000) begin
			@(posedge aclk);
			k++;
		end
		// a missing byte compares as unknown, a surplus one by the count
		while (exp_q.size() > 0)
			chk(far.got_q.size() > 0 ? {24'h0, far.got_q.pop_front()} : 32'hxxxxxxxx, {24'h0, exp_q.pop_front()});
		chk(32'(far.got_q.size()), 32'h0);
	endtask

	task automatic give_verdict;
		$display("checked %0d fails %0d", checked, fails);
		if (fails == 0 && checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		repeat (60000) @(posedge aclk);
		fails++;
		give_verdict();
	end

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		aresetn = 1'b0;
		pe = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		arvalid = 1'b0;
		awaddr = 32'h0;
		wdata = 32'h0;
		araddr = 32'h0;
		fails = 0;
		checked = 0;
		cyc = 0;
		void'($urandom(8));
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rchk(`UBD_OFF_FLAGS, 32'hf8, fl(1, 0, 0, 1, 0));
		rchk(`UBD_OFF_DIVISOR_WHOLE, 32'hffff, 32'h0);
		rchk(`UBD_OFF_DIVISOR_FRACTION, 32'h3f, 32'h0);
		for (int i = 0; i < 6; i++) begin
			v = (i == 0) ? 32'hffffffff : $urandom;
			wr(`UBD_OFF_DIVISOR_WHOLE, v);
			wr(`UBD_OFF_DIVISOR_FRACTION, ~v);
			chk({30'h0, rr}, {30'h0, `UBD_RESP_OKAY});
			rchk(`UBD_OFF_DIVISOR_WHOLE, 32'hffff, v & 32'hffff);
			rchk(`UBD_OFF_DIVISOR_FRACTION, 32'h3f, ~v & 32'h3f);
		end
		rd(12'h0f0, d);
		chk({30'h0, rr}, {30'h0, `UBD_RESP_SLVERR});
		wr(12'h0f0, 32'h0);
		chk({30'h0, rr}, {30'h0, `UBD_RESP_SLVERR});
		// divisors only act after a frame write, at the new rate
		pe <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			wr(`UBD_OFF_DIVISOR_WHOLE, 32'(wt[i]));
			wr(`UBD_OFF_DIVISOR_FRACTION, 32'(ft[i]));
			put(8'($urandom));
			rx_cmp();
			wr(`UBD_OFF_FRAME, 32'h0);
			far.bit_clks = bclk(wt[i], ft[i]);
			put(8'($urandom));
			rx_cmp();
		end
		// divisor change while a character is on the line
		put(8'ha5);
		wait (tx_line === 1'b0);
		wr(`UBD_OFF_DIVISOR_WHOLE, 32'h1);
		wr(`UBD_OFF_DIVISOR_FRACTION, 32'h0);
		wr(`UBD_OFF_FRAME, 32'h0);
		rx_cmp();
		far.bit_clks = 16;
		put(8'h5a);
		rx_cmp();
		// transmit side flags and busy span, holding register then queue
		for (int m = 0; m < 2; m++) begin
			n = m ? 16 : 1;
			repeat (20) @(posedge aclk);
			pe <= 1'b0;
			wr(`UBD_OFF_FRAME, 32'(m << 4));
			rchk(`UBD_OFF_FRAME, 32'hff, 32'(m << 4));
			for (int i = 0; i < n; i++) begin
				put(8'($urandom));
				rchk(`UBD_OFF_FLAGS, 32'hf8, fl(0, 0, i == n - 1, 1, 1));
			end
			pe <= 1'b1;
			wait (tx_line === 1'b0);
			t0 = cyc;
			do rd(`UBD_OFF_FLAGS, d); while (d[3] === 1'b1 && cyc - t0 < 9000);
			t0 = cyc - t0;
			chk(32'(t0 >= 160 * n && t0 <= 170 * n), 32'h1);
			chk(d & 32'hf8, fl(1, 0, 0, 1, 0));
			rx_cmp();
		end
		// receive side flags, holding register then queue
		for (int m = 0; m < 2; m++) begin
			n = m ? 16 : 1;
			wr(`UBD_OFF_FRAME, 32'(m << 4));
			for (int i = 0; i < n; i++) begin
				b = 8'($urandom);
				exp_q.push_back(b);
				far.send(b);
				if (i == n - 2) rchk(`UBD_OFF_FLAGS, 32'hf8, fl(1, 0, 0, 0, 0));
			end
			repeat (8) @(posedge aclk);
			rchk(`UBD_OFF_FLAGS, 32'hf8, fl(1, 1, 0, 0, 0));
			while (exp_q.size() > 0) rchk(`UBD_OFF_DATA, 32'hff, {24'h0, exp_q.pop_front()});
			rchk(`UBD_OFF_FLAGS, 32'hf8, fl(1, 0, 0, 1, 0));
		end
		// interrupt raised, cleared by status read, then masked
		wr(`UBD_OFF_IRQ_MASK, 32'h1);
		rchk(`UBD_OFF_IRQ_STAT, 32'h6, 32'h2);
		repeat (3) @(posedge aclk);
		chk(32'(irq), 32'h0);
		put(8'h3c);
		rx_cmp();
		repeat (20) @(posedge aclk);
		chk(32'(irq), 32'h1);
		rchk(`UBD_OFF_IRQ_STAT, 32'h1, 32'h1);
		repeat (3) @(posedge aclk);
		chk(32'(irq), 32'h0);
		wr(`UBD_OFF_IRQ_MASK, 32'h0);
		put(8'hc3);
		rx_cmp();
		repeat (20) @(posedge aclk);
		chk(32'(irq), 32'h0);
		give_verdict();
	end
endmodule

// file: verification/ubd_far_end.sv
// far-end serial device model: 8n1 receiver and sender
module ubd_far_end (
	input  wire logic aclk,
	input  wire logic tx_line,
	output logic      rx_line
);
	timeunit 1ns;
	timeprecision 1ps;

	int         bit_clks;
	logic [7:0] got_q[$];

	initial begin
		rx_line = 1'b1;
		bit_clks = 16;
	end

	// ------------------------------
	// receiver
	// ------------------------------
	// bit length latched at the start edge, each bit sampled mid-cell
	initial begin
		int         p;
		logic [7:0] b;
		forever begin
			@(negedge tx_line);
			p = bit_clks;
			repeat (p / 2) @(posedge aclk);
			for (int i = 0; i < 8; i++) begin
				repeat (p) @(posedge aclk);
				b[i] = tx_line;
			end
			repeat (p) @(posedge aclk);
			// bad stop bit stores an unknown so the compare fails
			got_q.push_back(tx_line ? b : 8'hxx);
		end
	end

	// ------------------------------
	// sender
	// ------------------------------
	// start, eight bits lsb first, stop; line left idle high
	task automatic send(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge aclk);
			rx_line <= f[i];
			repeat (bit_clks - 1) @(posedge aclk);
		end
	endtask
endmodule
